// ---- inc/sfw_consts.svh ----
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH

// Time base: the clock period and the microsecond, both in nanoseconds.
`define SFW_CLK_PERIOD_NS        32'h0000_0064
`define SFW_NS_PER_US            32'h0000_03e8

// Line shift times in nanoseconds (35.000, 24.725, 28.475, 31.412, 30.775, 33.500, 37.025 us).
`define SFW_SHIFT_BASE_NS        16'h88b8
`define SFW_SHIFT_LARGE_8_NS     16'h6095
`define SFW_SHIFT_LARGE_12_NS    16'h6f3b
`define SFW_SHIFT_LARGE_16_NS    16'h7ab4
`define SFW_SHIFT_TOP_8_NS       16'h7837
`define SFW_SHIFT_TOP_12_NS      16'h82dc
`define SFW_SHIFT_TOP_16_NS      16'h90a1

// Register byte offsets.
`define SFW_OFS_CTRL             8'h00
`define SFW_OFS_EXPOSURE         8'h04
`define SFW_OFS_ROWS             8'h08
`define SFW_OFS_READOUT          8'h0c
`define SFW_OFS_STATUS           8'h10
`define SFW_OFS_COUNT            8'h14
`define SFW_OFS_PERIOD           8'h18

// Control register fields.
`define SFW_CTRL_SHUTTER_BIT     0
`define SFW_CTRL_VARIANT_LSB     1
`define SFW_CTRL_DEPTH_LSB       3
`define SFW_CTRL_WIDTH_MODE_BIT  5
`define SFW_CTRL_ENABLE_BIT      6

// Status register fields.
`define SFW_STAT_FLASH_BIT       0
`define SFW_STAT_EXPOSING_BIT    1
`define SFW_STAT_READING_BIT     2
`define SFW_STAT_OVERLAP_BIT     3
`define SFW_STAT_OVERTRIG_BIT    4

// Reset values.
`define SFW_EXPOSURE_RST         20'h0_2710
`define SFW_ROWS_RST             12'h400

`endif

// ---- inc/sfw_pkg.sv ----
package sfw_pkg;

    typedef enum logic
    {
        staggered_select_value   = 1'b0,
        simultaneous_reset_value = 1'b1
    } sfw_shutter_t;

    typedef enum logic [1:0]
    {
        SFW_VAR_BASE  = 2'b00,
        SFW_VAR_LARGE = 2'b01,
        SFW_VAR_TOP   = 2'b10
    } sfw_variant_t;

    typedef enum logic [1:0]
    {
        SFW_DEPTH_8  = 2'b00,
        SFW_DEPTH_12 = 2'b01,
        SFW_DEPTH_16 = 2'b10
    } sfw_depth_t;

    typedef enum logic
    {
        SFW_ST_IDLE   = 1'b0,
        SFW_ST_EXPOSE = 1'b1
    } sfw_exp_state_t;

    // Saturating add so long idle gaps never wrap a time counter.
    function automatic logic [31:0] sfw_sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[32] ? 32'hffff_ffff : sum[31:0];
    endfunction

endpackage

// ---- src/sfw_shift_lut.sv ----
`timescale 1ns/1ps
`include "sfw_consts.svh"

module sfw_shift_lut
(
    input  wire sfw_pkg::sfw_variant_t variant_i,
    input  wire sfw_pkg::sfw_depth_t   depth_i,
    output logic [15:0]                line_shift_time_o
);
    import sfw_pkg::*;

    always_comb
    begin
        line_shift_time_o = `SFW_SHIFT_BASE_NS;
        unique case (variant_i)
            SFW_VAR_LARGE:
            begin
                unique case (depth_i)
                    SFW_DEPTH_8:  line_shift_time_o = `SFW_SHIFT_LARGE_8_NS;
                    SFW_DEPTH_12: line_shift_time_o = `SFW_SHIFT_LARGE_12_NS;
                    SFW_DEPTH_16: line_shift_time_o = `SFW_SHIFT_LARGE_16_NS;
                    default:      line_shift_time_o = `SFW_SHIFT_LARGE_8_NS;
                endcase
            end
            SFW_VAR_TOP:
            begin
                unique case (depth_i)
                    SFW_DEPTH_8:  line_shift_time_o = `SFW_SHIFT_TOP_8_NS;
                    SFW_DEPTH_12: line_shift_time_o = `SFW_SHIFT_TOP_12_NS;
                    SFW_DEPTH_16: line_shift_time_o = `SFW_SHIFT_TOP_16_NS;
                    default:      line_shift_time_o = `SFW_SHIFT_TOP_8_NS;
                endcase
            end
            default: line_shift_time_o = `SFW_SHIFT_BASE_NS;
        endcase
    end

endmodule

// ---- src/sfw_top.sv ----
`timescale 1ns/1ps
`include "sfw_consts.svh"

// Function
// - Two shutter modes, staggered and simultaneous reset, chosen by configuration.
// - Staggered: window opens line shift times region rows minus one after trigger.
// - Staggered: window width is exposure (or an earlier trigger end in width mode) minus line shift times rows minus one.
// - Base sensor variant uses a 35 us line shift at every depth.
// - Large variant uses 24.725, 28.475 or 31.412 us by depth.
// - Top variant uses 30.775, 33.500 or 37.025 us by depth.
// - Simultaneous reset: window opens at the trigger with no line delay.
// - Simultaneous reset: window closes after the configured exposure time, or at an earlier trigger end in width mode.
// - Flash output is high while the window is open, low otherwise.
// - Readout of a frame starts only after its exposure has ended.
// - Frames overlap when trigger period is at most exposure plus readout.
// - A new exposure may start while the previous readout is running.
// - Readout duration in microseconds for the current setup is readable.
// - Exposure ending during a running readout drops the frame, flags overtrigger.
// - Staggered mode suppresses the window when exposure is below the line delay.
module sfw_top
#(
    parameter int unsigned ROWS_W = 12,
    parameter int unsigned EXP_W  = 20,
    parameter int unsigned CNT_W  = 16
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        frame_trigger_i,
    input  wire logic        trigger_end_i,
    output logic             flash_window_o,
    output logic             exposing_o,
    output logic             reading_o,
    output logic             overtrigger_o,
    output logic             frame_done_o
);
    import sfw_pkg::*;

    typedef struct packed {
        sfw_exp_state_t    exp_state;
        sfw_shutter_t      shutter_select;
        sfw_variant_t      variant;
        sfw_depth_t        depth;
        logic              width_mode;
        logic              enable;
        logic [EXP_W-1:0]  exposure_us;
        logic [ROWS_W-1:0] region_rows;
        logic [31:0]       open_at_ns;
        logic [31:0]       close_at_ns;
        logic              suppress;
        logic [31:0]       frame_readout_ns;
        logic [31:0]       elapsed_ns;
        logic [31:0]       period_ns;
        logic [31:0]       budget_ns;
        logic              have_prev;
        logic              reading;
        logic [31:0]       read_ns;
        logic [31:0]       read_len_ns;
        logic              flash;
        logic              overlapped;
        logic              ovt_sticky;
        logic              ovt_pulse;
        logic              done_pulse;
        logic [CNT_W-1:0]  accepted;
        logic [CNT_W-1:0]  dropped;
        logic [31:0]       last_period_ns;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } sfw_top_state_t;

    sfw_top_state_t s;
    sfw_top_state_t next_s;

    logic [15:0] line_shift_time;
    logic [31:0] calc_open_ns;
    logic [31:0] calc_close_ns;
    logic [31:0] calc_readout_ns;
    logic [31:0] readout_duration_value;
    logic        calc_suppress;
    logic [31:0] exp_time;
    logic [31:0] read_time;
    logic        exposure_end;
    logic        ovt_set;
    logic        wr_access;
    logic [31:0] rd_word;
    logic        rd_hit;

    sfw_shift_lut u_shift_lut
    (
        .variant_i         (s.variant),
        .depth_i           (s.depth),
        .line_shift_time_o (line_shift_time)
    );

    sfw_window_calc
    #(
        .ROWS_W (ROWS_W),
        .EXP_W  (EXP_W)
    )
    u_window_calc
    (
        .line_shift_time_i (line_shift_time),
        .region_rows_i     (s.region_rows),
        .exposure_us_i     (s.exposure_us),
        .shutter_select_i  (s.shutter_select),
        .open_at_ns_o      (calc_open_ns),
        .close_at_ns_o     (calc_close_ns),
        .readout_ns_o      (calc_readout_ns),
        .readout_us_o      (readout_duration_value),
        .suppress_o        (calc_suppress)
    );

    // Window state for the cycle that starts at time t after the trigger.
    function automatic logic flash_on(input logic [31:0] t, input logic [31:0] open_at,
                                      input logic [31:0] close_at, input logic suppress);
        return !suppress && (t >= open_at) && (t < close_at);
    endfunction

    // Exposure decode shared by the status word and the exposing output.
    function automatic logic is_exposing(input sfw_exp_state_t st);
        return st == SFW_ST_EXPOSE;
    endfunction

    // Read multiplexer; unmapped addresses return zero and flag an error.
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr_i)
            `SFW_OFS_CTRL:
            begin
                rd_word[`SFW_CTRL_SHUTTER_BIT]                           = s.shutter_select;
                rd_word[`SFW_CTRL_VARIANT_LSB +: 2]                      = s.variant;
                rd_word[`SFW_CTRL_DEPTH_LSB +: 2]                        = s.depth;
                rd_word[`SFW_CTRL_WIDTH_MODE_BIT]                        = s.width_mode;
                rd_word[`SFW_CTRL_ENABLE_BIT]                            = s.enable;
            end
            `SFW_OFS_EXPOSURE: rd_word[EXP_W-1:0]  = s.exposure_us;
            `SFW_OFS_ROWS:     rd_word[ROWS_W-1:0] = s.region_rows;
            `SFW_OFS_READOUT:  rd_word             = readout_duration_value;
            `SFW_OFS_STATUS:
            begin
                rd_word[`SFW_STAT_FLASH_BIT]    = s.flash;
                rd_word[`SFW_STAT_EXPOSING_BIT] = is_exposing(s.exp_state);
                rd_word[`SFW_STAT_READING_BIT]  = s.reading;
                rd_word[`SFW_STAT_OVERLAP_BIT]  = s.overlapped;
                rd_word[`SFW_STAT_OVERTRIG_BIT] = s.ovt_sticky;
            end
            `SFW_OFS_COUNT:    rd_word = {s.dropped, s.accepted};
            `SFW_OFS_PERIOD:   rd_word = s.last_period_ns;
            default:           rd_hit  = 1'b0;
        endcase
    end

    always_comb
    begin
        next_s            = s;
        next_s.ovt_pulse  = 1'b0;
        next_s.done_pulse = 1'b0;
        next_s.pready     = 1'b0;
        next_s.pslverr    = 1'b0;
        ovt_set           = 1'b0;
        exposure_end      = 1'b0;
        exp_time          = sfw_sat_add(s.elapsed_ns, `SFW_CLK_PERIOD_NS);
        read_time         = sfw_sat_add(s.read_ns, `SFW_CLK_PERIOD_NS);
        wr_access         = psel_i && penable_i && s.pready && pwrite_i;
        // Saturation keeps a long idle gap from wrapping into a false overlap.
        next_s.period_ns  = sfw_sat_add(s.period_ns, `SFW_CLK_PERIOD_NS);

        // Readout engine: one frame at a time, length fixed when its exposure started.
        if (s.reading)
        begin
            if (read_time >= s.read_len_ns)
            begin
                next_s.reading    = 1'b0;
                next_s.done_pulse = 1'b1;
            end
            else
            begin
                next_s.read_ns = read_time;
            end
        end

        unique case (s.exp_state)
            SFW_ST_IDLE:
            begin
                next_s.flash = 1'b0;
                // A trigger is taken even while the previous frame is reading out.
                // Clearing enable blocks new triggers only; a running frame still finishes.
                if (s.enable && frame_trigger_i)
                begin
                    // Timing is latched here so only a width-mode write can reshape a running window.
                    next_s.exp_state        = SFW_ST_EXPOSE;
                    next_s.elapsed_ns       = `SFW_CLK_PERIOD_NS;
                    next_s.open_at_ns       = calc_open_ns;
                    next_s.close_at_ns      = calc_close_ns;
                    next_s.suppress         = calc_suppress;
                    next_s.frame_readout_ns = calc_readout_ns;
                    next_s.flash            = flash_on(`SFW_CLK_PERIOD_NS, calc_open_ns,
                                                       calc_close_ns, calc_suppress);
                    if (s.have_prev)
                    begin
                        next_s.overlapped     = (s.period_ns <= s.budget_ns);
                        next_s.last_period_ns = s.period_ns;
                    end
                    next_s.budget_ns = sfw_sat_add(calc_close_ns, calc_readout_ns);
                    next_s.period_ns = `SFW_CLK_PERIOD_NS;
                    next_s.have_prev = 1'b1;
                end
            end
            SFW_ST_EXPOSE:
            begin
                next_s.elapsed_ns = exp_time;
                next_s.flash      = flash_on(exp_time, s.open_at_ns,
                                             s.close_at_ns, s.suppress);
                if (s.width_mode)
                begin
                    exposure_end = trigger_end_i;
                end
                else
                begin
                    exposure_end = (exp_time >= s.close_at_ns);
                end
                if (exposure_end)
                begin
                    next_s.exp_state = SFW_ST_IDLE;
                    // A drop is known only now, so a dropped frame may have shown part of its window.
                    next_s.flash     = 1'b0;
                    // Readout that still runs after this edge blocks the new frame.
                    if (s.reading && next_s.reading)
                    begin
                        next_s.dropped   = s.dropped + CNT_W'(1);
                        next_s.ovt_pulse = 1'b1;
                        ovt_set          = 1'b1;
                    end
                    else
                    begin
                        next_s.reading     = 1'b1;
                        next_s.read_ns     = 32'h0000_0000;
                        next_s.read_len_ns = s.frame_readout_ns;
                        next_s.accepted    = s.accepted + CNT_W'(1);
                    end
                end
            end
        endcase

        // Zero-wait APB slave: the answer is prepared in the setup cycle.
        if (psel_i && !penable_i)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !rd_hit;
            next_s.prdata  = (pwrite_i || !rd_hit) ? 32'h0000_0000 : rd_word;
        end

        // Writes land at the access edge, the one at which the master sees pready high.
        if (wr_access)
        begin
            unique case (paddr_i)
                `SFW_OFS_CTRL:
                begin
                    next_s.shutter_select = sfw_shutter_t'(pwdata_i[`SFW_CTRL_SHUTTER_BIT]);
                    next_s.variant        = sfw_variant_t'(pwdata_i[`SFW_CTRL_VARIANT_LSB +: 2]);
                    next_s.depth          = sfw_depth_t'(pwdata_i[`SFW_CTRL_DEPTH_LSB +: 2]);
                    next_s.width_mode     = pwdata_i[`SFW_CTRL_WIDTH_MODE_BIT];
                    next_s.enable         = pwdata_i[`SFW_CTRL_ENABLE_BIT];
                end
                `SFW_OFS_EXPOSURE: next_s.exposure_us = pwdata_i[EXP_W-1:0];
                `SFW_OFS_ROWS:     next_s.region_rows = pwdata_i[ROWS_W-1:0];
                `SFW_OFS_STATUS:
                begin
                    if (pwdata_i[`SFW_STAT_OVERTRIG_BIT])
                    begin
                        next_s.ovt_sticky = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // A new overtrigger wins over a clear in the same cycle.
        if (ovt_set)
        begin
            next_s.ovt_sticky = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s             <= '0;
            s.exposure_us <= `SFW_EXPOSURE_RST;
            s.region_rows <= `SFW_ROWS_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata_o       = s.prdata;
    assign pready_o       = s.pready;
    assign pslverr_o      = s.pslverr;
    assign flash_window_o = s.flash;
    assign exposing_o     = is_exposing(s.exp_state);
    assign reading_o      = s.reading;
    assign overtrigger_o  = s.ovt_pulse;
    assign frame_done_o   = s.done_pulse;

endmodule

// ---- src/sfw_window_calc.sv ----
`timescale 1ns/1ps
`include "sfw_consts.svh"

module sfw_window_calc
#(
    parameter int unsigned ROWS_W = 12,
    parameter int unsigned EXP_W  = 20
)
(
    input  wire logic [15:0]           line_shift_time_i,
    input  wire logic [ROWS_W-1:0]     region_rows_i,
    input  wire logic [EXP_W-1:0]      exposure_us_i,
    input  wire sfw_pkg::sfw_shutter_t shutter_select_i,
    output logic [31:0]                open_at_ns_o,
    output logic [31:0]                close_at_ns_o,
    output logic [31:0]                readout_ns_o,
    output logic [31:0]                readout_us_o,
    output logic                       suppress_o
);
    import sfw_pkg::*;

    logic [ROWS_W-1:0] rows_eff;
    logic [31:0]       delay_ns;

    always_comb
    begin
        // A zero height is treated as a single line.
        rows_eff      = (region_rows_i == '0) ? ROWS_W'(1) : region_rows_i;
        delay_ns      = 32'(line_shift_time_i) * 32'(rows_eff - ROWS_W'(1));
        readout_ns_o  = 32'(line_shift_time_i) * 32'(rows_eff);
        readout_us_o  = readout_ns_o / `SFW_NS_PER_US;
        close_at_ns_o = 32'(exposure_us_i) * `SFW_NS_PER_US;
        unique case (shutter_select_i)
            staggered_select_value:
            begin
                open_at_ns_o = delay_ns;
                suppress_o   = close_at_ns_o < delay_ns;
            end
            simultaneous_reset_value:
            begin
                open_at_ns_o = 32'h0000_0000;
                suppress_o   = 1'b0;
            end
        endcase
    end

endmodule

// ---- verification/sfw_far_end.sv ----
`timescale 1ns/1ps
module sfw_far_end
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        go_i,
    input  wire logic [15:0] end_dly_i,
    input  wire logic        flash_window_i,
    output logic             frame_trigger_o,
    output logic             trigger_end_o,
    output int               rise_at_o,
    output int               width_o
);
    int k;

    // The trigger is a one-cycle pulse and idles low between frames.
    assign frame_trigger_o = go_i;

    always @(posedge clk_i)
    begin
        if (!rst_n_i || go_i)
        begin
            k         <= 1;
            width_o   <= 0;
            rise_at_o <= 0;
        end
        else
        begin
            k <= k + 1;
            if (flash_window_i === 1'b1)
            begin
                rise_at_o <= (width_o == 0) ? k : rise_at_o;
                width_o   <= width_o + 1;
            end
        end
        // Exposure is ended early only at the cycle the bench asks for.
        trigger_end_o <= rst_n_i && !go_i && (k + 1 == int'(end_dly_i));
    end
endmodule

// ---- verification/sfw_top_props.sv ----
`timescale 1ns/1ps
module sfw_top_props
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        frame_trigger_i,
    input wire logic        trigger_end_i,
    input wire logic        flash_window_o,
    input wire logic        exposing_o,
    input wire logic        reading_o,
    input wire logic        overtrigger_o,
    input wire logic        frame_done_o
);
    logic exp_q;
    logic used_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Remembers whether the current exposure has already had its flash window.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            exp_q  <= 1'b0;
            used_q <= 1'b0;
        end
        else
        begin
            exp_q  <= exposing_o;
            used_q <= (exposing_o && !exp_q) ? flash_window_o : (used_q | flash_window_o);
        end
    end

    a_pready_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    a_pready_once: assert property (psel_i && penable_i |=> !pready_o)
        else $error("pready held too long");
    a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
        else $error("error response carries data");
    a_exp_cause: assert property ($rose(exposing_o) |-> $past(frame_trigger_i))
        else $error("exposure without trigger");
    a_read_after: assert property ($rose(reading_o) |-> $fell(exposing_o))
        else $error("readout before exposure end");
    a_flash_exp: assert property (flash_window_o |-> exposing_o)
        else $error("flash outside exposure");
    a_drop_quiet: assert property (overtrigger_o |-> reading_o && !exposing_o && !flash_window_o)
        else $error("bad state at dropped frame");
    a_ot_pulse: assert property (overtrigger_o |=> !overtrigger_o)
        else $error("overtrigger longer than a cycle");
    a_done_read: assert property (frame_done_o |-> $past(reading_o) && (!reading_o || $fell(exposing_o)))
        else $error("frame done without readout");
    a_flash_once: assert property ($rose(flash_window_o) && exp_q |-> !used_q)
        else $error("second flash window in one frame");

    c_drop: cover property (overtrigger_o);
    c_flash: cover property ($fell(flash_window_o));
    c_err: cover property (pslverr_o);
endmodule

bind sfw_top sfw_top_props u_props
(
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_trigger_i(frame_trigger_i),
    .trigger_end_i(trigger_end_i), .flash_window_o(flash_window_o),
    .exposing_o(exposing_o), .reading_o(reading_o), .overtrigger_o(overtrigger_o),
    .frame_done_o(frame_done_o)
);

// ---- verification/shutter_flash_window_timing_tb.sv ----
`timescale 1ns/1ps
`include "sfw_consts.svh"
module shutter_flash_window_timing_tb;
    localparam int ROWS_SET = 3;
    logic        clk;
    logic        rst_n;
    logic        psel, penable, pwrite, pready, pslverr, ev;
    logic        go, trig, tend, flash, expo, rdg, ot, done;
    logic [7:0]  paddr;
    logic [15:0] end_dly;
    logic [31:0] pwdata, prdata, rv;
    int          err_total, tests_run, ot_n, seed, rise_at, width, rw, acc_n, drop_n;
    int          cyc, t_go, per;
    int          sh [3][3] = '{'{35000, 35000, 35000}, '{24725, 28475, 31412},
                               '{30775, 33500, 37025}};

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sfw_far_end u_far (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .end_dly_i(end_dly),
        .flash_window_i(flash), .frame_trigger_o(trig), .trigger_end_o(tend),
        .rise_at_o(rise_at), .width_o(width));

    sfw_top DUT (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .frame_trigger_i(trig),
        .trigger_end_i(tend), .flash_window_o(flash), .exposing_o(expo),
        .reading_o(rdg), .overtrigger_o(ot), .frame_done_o(done));

    always @(posedge clk)
        if (ot === 1'b1)
            ot_n <= ot_n + 1;

    always @(posedge clk)
        cyc <= cyc + 1;

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, x, g);
        end
    endtask

    task automatic wait_on(ref logic s, input logic v);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (s !== v && n < 5000);
        if (n >= 5000)
            chk("wait", 32'(v), 32'(s));
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        wait_on(pready, 1'b1);
        rv = prdata;
        ev = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, x, rv);
    endtask

    // Runs one frame and compares the measured flash window with the model.
    task automatic frame(input int sel, input int wm, input int exp_us, input int ed,
                         input int fin, input int drop);
        int oc;
        int ec;
        oc = sel ? 1 : sh[0][0] * (ROWS_SET - 1) / 100;
        ec = (ed != 0 && ed < exp_us * 10) ? ed + 1 : exp_us * 10;
        wr(`SFW_OFS_CTRL, 32'(32'h0000_0040 | (wm << 5) | sel));
        wr(`SFW_OFS_EXPOSURE, 32'(exp_us));
        end_dly <= 16'(ed);
        go      <= 1'b1;
        @(posedge clk);
        per  = (cyc - t_go) * 100;
        t_go = cyc;
        go <= 1'b0;
        wait_on(expo, 1'b0);
        if (fin)
            wait_on(done, 1'b1);
        if (drop)
            drop_n++;
        else
            acc_n++;
        chk("flash_rise", (drop || ec <= oc) ? 0 : oc, 32'(rise_at));
        chk("flash_width", (drop || ec <= oc) ? 0 : ec - oc, 32'(width));
    endtask

    initial
    begin
        {err_total, tests_run, ot_n, acc_n, drop_n} = '0;
        seed = 92;
        {rst_n, psel, penable, pwrite, go} = '0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        end_dly = 16'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc("ctrl", `SFW_OFS_CTRL, 32'h0000_0000);
        rdc("exposure", `SFW_OFS_EXPOSURE, 32'h0000_2710);
        rdc("rows", `SFW_OFS_ROWS, 32'h0000_0400);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0000_0000, ev});
        wr(`SFW_OFS_ROWS, 32'h0000_0000);
        rdc("readout0", `SFW_OFS_READOUT, 32'h0000_0023);
        for (int v = 0; v < 3; v++)
            for (int d = 0; d < 3; d++)
            begin
                rw = {$random(seed)} % 4095 + 1;
                wr(`SFW_OFS_ROWS, 32'(rw));
                wr(`SFW_OFS_CTRL, 32'((v << 1) | (d << 3)));
                rdc("readout", `SFW_OFS_READOUT, 32'(sh[v][d] * rw / 1000));
            end
        wr(`SFW_OFS_ROWS, 32'(ROWS_SET));
        frame(0, 0, 100, 0, 1, 0);
        frame(1, 0, 100, 0, 1, 0);
        rdc("status", `SFW_OFS_STATUS, 32'h0000_0000);
        frame(0, 0, 50, 0, 1, 0);
        frame(0, 1, 100, 20, 0, 0);
        frame(0, 1, 100, 20, 0, 1);
        rdc("status", `SFW_OFS_STATUS, 32'h0000_001c);
        chk("overtrig", 32'h0000_0001, 32'(ot_n));
        wr(`SFW_OFS_STATUS, 32'h0000_0010);
        wait_on(done, 1'b1);
        apb(1'b0, `SFW_OFS_STATUS, 32'h0000_0000);
        chk("sticky", 32'h0000_0000, rv & 32'h0000_0010);
        frame(0, 1, 100, 1200, 1, 0);
        chk("overtrig", 32'h0000_0001, 32'(ot_n));
        rdc("count", `SFW_OFS_COUNT, {16'(drop_n), 16'(acc_n)});
        rdc("period", `SFW_OFS_PERIOD, 32'(per));
        finish_test;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        finish_test;
    end
endmodule
